// ==== rtl/bea_access_unit.sv ====
// byte-wide nonvolatile access unit, cpu i/o register side
// assumes the cpu drives io strobes on core_clk and honours cpu_stall
//
// Function
// R1: separate 512-byte array, bytes individually accessible
// R2: all access registers sit in i/o space
// R3: writes self-timed, completion visible by polling
// R4: write needs arm then strobe sequence
// R5: read stalls cpu four cycles
// R6: write start stalls cpu two cycles
// R7: address bits 15..9 ignore writes, read zero
// R8: nine-bit address selects bytes 0 to 511
// R9: address register has no reset value
// R10: software loads a valid address before access
// R11: write stores data register byte at address
// R12: read loads data register from addressed byte
// R13: arm self-clears after four; strobe needs arm
// R14: write strobe held until write time elapses
// R15: read immediate; reads, address changes refused busy
// R16: ready interrupt while enabled and strobe clear
// R17: address and data captured for whole write
// R18: io strobes decode four registers on clock edge
`timescale 1ns/100ps
module bea_access_unit #(
  parameter int WRITE_CYCLES = bea_pkg::WRITE_CORE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [bea_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  input wire logic global_irq_enable,
  output logic cpu_stall,
  output logic ready_irq
);
  import bea_pkg::*;

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0] mem_q [ARRAY_BYTES]; // nonvolatile array [R1]
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic ready_irq_enable_q;
  logic [2:0] arm_cnt_q;
  logic write_strobe_q;
  logic [2:0] stall_q;
  logic [7:0] rdata_q;

  logic wr_addr_high;
  logic wr_addr_low;
  logic wr_data;
  logic wr_ctrl;
  logic write_arm;
  logic rd_go;
  logic wr_go;
  logic wr_busy;
  logic wr_done;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [IO_ADDR_W-1:0] a,
                               input logic [IO_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // write strobes per register [R2] [R18]
  assign wr_addr_high = io_we && hit(io_addr, OFS_ADDR_HIGH);
  assign wr_addr_low = io_we && hit(io_addr, OFS_ADDR_LOW);
  assign wr_data = io_we && hit(io_addr, OFS_DATA);
  assign wr_ctrl = io_we && hit(io_addr, OFS_CTRL);

  // arm is live while its window counter runs
  assign write_arm = (arm_cnt_q != 3'h0);

  // read trigger, refused during a write [R15]
  assign rd_go = wr_ctrl && io_wdata[BIT_READ_STROBE] && !write_strobe_q;

  // write start only with arm already set and no write running [R4]
  assign wr_go = wr_ctrl && io_wdata[BIT_WRITE_STROBE] && write_arm &&
                 !write_strobe_q; // [R13]

  assign rd_byte = mem_q[addr_q]; // linear byte select [R8]

  // ----------------------------------------------------------------
  // write duration timer
  // ----------------------------------------------------------------
  bea_write_timer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(wr_go),
    .busy(wr_busy),
    .done(wr_done)
  );

  // ----------------------------------------------------------------
  // address register, no reset value
  // ----------------------------------------------------------------
  // updates ignored while a write is in progress [R15] [R9]
  always_ff @(posedge core_clk) begin
    if (!write_strobe_q) begin
      if (wr_addr_high) begin
        addr_q[8] <= io_wdata[0]; // bits 15..9 dropped [R7]
      end
      if (wr_addr_low) begin
        addr_q[7:0] <= io_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------
  // software load, or array byte on a read [R12]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_q <= RST_DATA;
    end else if (rd_go) begin
      data_q <= rd_byte; // [R12]
    end else if (wr_data) begin
      data_q <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // control register bits
  // ----------------------------------------------------------------
  // interrupt enable is plain read/write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ready_irq_enable_q <= RST_READY_IRQ_EN;
    end else if (wr_ctrl) begin
      ready_irq_enable_q <= io_wdata[BIT_READY_IRQ_EN];
    end
  end

  // arm window reloads on a write of one, then counts out [R13]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arm_cnt_q <= 3'h0;
    end else if (wr_ctrl && io_wdata[BIT_WRITE_ARM]) begin
      arm_cnt_q <= ARM_CYCLES; // [R13]
    end else if (write_arm) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end

  // write strobe stays set for the whole timed write [R14] [R3]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_strobe_q <= 1'b0;
    end else if (wr_go) begin
      write_strobe_q <= 1'b1;
    end else if (wr_done) begin
      write_strobe_q <= 1'b0; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // array write path
  // ----------------------------------------------------------------
  // capture address and data at write start [R17]
  always_ff @(posedge core_clk) begin
    if (wr_go) begin
      wr_addr_q <= addr_q;
      wr_data_q <= data_q; // [R11]
    end
  end

  // commit the byte when the write time ends, reset abandons it [R11] [R1]
  always_ff @(posedge core_clk) begin
    if (wr_done && !rst) begin
      mem_q[wr_addr_q] <= wr_data_q;
    end
  end

  // ----------------------------------------------------------------
  // cpu stall
  // ----------------------------------------------------------------
  // four cycles after a read, two after a write start [R5] [R6]
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall_q <= 3'h0;
    end else if (rd_go) begin
      stall_q <= READ_STALL_CYCLES; // [R5]
    end else if (wr_go) begin
      stall_q <= WRITE_STALL_CYCLES; // [R6]
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  assign cpu_stall = (stall_q != 3'h0);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // registered read mux, unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (io_re) begin
      case (io_addr)
        OFS_ADDR_HIGH: rdata_q <= {7'h00, addr_q[8]}; // [R7]
        OFS_ADDR_LOW: rdata_q <= addr_q[7:0];
        OFS_DATA: rdata_q <= data_q;
        OFS_CTRL: rdata_q <= {4'h0, ready_irq_enable_q, write_arm,
                              write_strobe_q, 1'b0}; // [R3]
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign io_rdata = rdata_q;

  // ready interrupt is a level while no write runs [R16]
  assign ready_irq = ready_irq_enable_q && global_irq_enable &&
                     !write_strobe_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_arm_window: assert property ( // [R13]
    (wr_ctrl && io_wdata[BIT_WRITE_ARM]) |=> write_arm[*4])
    else $error("arm window shorter than four cycles");

  a_arm_expiry: assert property ( // [R13]
    (arm_cnt_q == 3'h1 && !(wr_ctrl && io_wdata[BIT_WRITE_ARM]))
    |=> !write_arm)
    else $error("arm did not clear after four cycles");

  a_strobe_needs_arm: assert property ( // [R4]
    $rose(write_strobe_q) |-> $past(write_arm))
    else $error("write started without arm");

  a_read_stall: assert property ( // [R5]
    rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");

  a_write_stall: assert property ( // [R6]
    wr_go |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");

  a_strobe_clear: assert property ( // [R14]
    (write_strobe_q && !wr_done) |=> write_strobe_q)
    else $error("write strobe dropped before write end");

  a_done_clears: assert property ( // [R14]
    wr_done |=> !write_strobe_q && mem_q[$past(wr_addr_q)] ==
    $past(wr_data_q))
    else $error("write end did not commit and clear");

  a_addr_busy_hold: assert property ( // [R15]
    (write_strobe_q && (wr_addr_low || wr_addr_high)) |=> $stable(addr_q))
    else $error("address changed during write");

  a_read_data: assert property ( // [R12]
    rd_go |=> data_q == $past(rd_byte))
    else $error("read did not load data register");

  a_read_busy: assert property ( // [R15]
    (write_strobe_q && !wr_data) |=> $stable(data_q))
    else $error("data register changed by refused read");

  a_irq_gate: assert property ( // [R16]
    write_strobe_q |-> !ready_irq)
    else $error("ready interrupt during write");

  a_rsv_zero: assert property ( // [R7]
    (io_re && io_addr == OFS_ADDR_HIGH) |=> io_rdata[7:1] == 7'h00)
    else $error("reserved address bits not zero");

  a_strobe_no_arm: assert property ( // [R13]
    (wr_ctrl && io_wdata[BIT_WRITE_STROBE] && !write_arm && !write_strobe_q)
    |=> !write_strobe_q)
    else $error("write started without live arm");

  a_busy_visible: assert property ( // [R3]
    (io_re && io_addr == OFS_CTRL) |=> io_rdata[1] == $past(write_strobe_q))
    else $error("write progress not visible in control read");

  // main scenarios
  c_read: cover property (rd_go ##5 !cpu_stall);
  c_ready_irq: cover property (wr_done ##1 ready_irq);
  c_write_done: cover property (wr_go ##[1:1000] wr_done);
  c_write_no_arm: cover property (
    wr_ctrl && io_wdata[BIT_WRITE_STROBE] && !write_arm);
  c_read_refused: cover property (
    wr_ctrl && io_wdata[BIT_READ_STROBE] && write_strobe_q);

endmodule : bea_access_unit

// ==== shared/bea_pkg.sv ====
// package for the byte-wide nonvolatile access unit
// assumes the cpu core clock runs at 50 mhz and the write timing
// oscillator is a nominal 1 mhz source derived from that clock
package bea_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ARRAY_BYTES = 512;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 6;

  // ----------------------------------------------------------------
  // i/o space offsets of the access registers
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h1f;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h1e;
  localparam logic [5:0] OFS_DATA = 6'h1d;
  localparam logic [5:0] OFS_CTRL = 6'h1c;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_WRITE_STROBE = 1;
  localparam int BIT_WRITE_ARM = 2;
  localparam int BIT_READY_IRQ_EN = 3;
  localparam logic RST_READY_IRQ_EN = 1'b0;
  localparam logic [7:0] RST_DATA = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int WRITE_CORE_CYCLES = WRITE_OSC_CYCLES * OSC_DIV;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam int TIMER_W = 20;

endpackage : bea_pkg

// ==== rtl/bea_write_timer.sv ====
// self-timed write duration counter
// assumes start is a one-cycle pulse that never arrives while busy
`timescale 1ns/100ps
module bea_write_timer #(
  parameter int WRITE_CYCLES = bea_pkg::WRITE_CORE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  import bea_pkg::*;

  localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(WRITE_CYCLES - 1);

  logic [TIMER_W-1:0] cnt_q;
  logic run_q;

  // ----------------------------------------------------------------
  // down counter of core cycles for one byte write
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_q <= 1'b0;
      cnt_q <= '0;
    end else if (start) begin
      run_q <= 1'b1;
      cnt_q <= LOAD;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - TIMER_W'(1);
      end
    end
  end

  assign busy = run_q;
  assign done = run_q && (cnt_q == '0); // last cycle of the write

endmodule : bea_write_timer

// ==== verif/bea_cpu_model.sv ====
// cpu core model: drives the i/o strobes of the access unit
// assumes the bench waits out cpu_stall before each call
`timescale 1ns/100ps
module bea_cpu_model (
  input wire logic core_clk,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_we,
  output logic io_re,
  input wire logic [7:0] io_rdata
);
  import bea_pkg::*;

  // idle bus at time zero
  initial begin
    io_addr = 6'h00;
    io_wdata = 8'h00;
    io_we = 1'b0;
    io_re = 1'b0;
  end

  // one write, strobe up for a single taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(posedge core_clk);
    #1;
    io_we = 1'b0;
    io_addr = ~a; // released lines do not keep their value
    io_wdata = ~d;
  endtask : wr

  // one read, data taken just after the answering edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_re = 1'b1;
    @(posedge core_clk);
    #1;
    io_re = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask : rd

  // address, data, then arm and strobe on consecutive writes
  task automatic start_write(input logic [8:0] a, input logic [7:0] d);
    wr(OFS_ADDR_HIGH, {7'h7f, a[8]}); // reserved bits set on purpose
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, 8'h0c);
    wr(OFS_CTRL, 8'h0a);
  endtask : start_write
endmodule : bea_cpu_model

// ==== verif/tb.sv ====
// self-checking bench for the nonvolatile access unit
// assumes the cpu model in bea_cpu_model.sv makes every request
`timescale 1ns/100ps
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("wrong value at %0t: %h %h", $time, a, b); \
  end \
end
module tb;
  import bea_pkg::*;
  localparam int WC = 20;
  logic core_clk, rst, global_irq_enable, io_we, io_re;
  logic cpu_stall, ready_irq;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, v;
  int n_mismatch = 0;
  int n_compared = 0;
  int s, n;

  // 50 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  bea_access_unit #(.WRITE_CYCLES(WC)) uut (.core_clk(core_clk),
    .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq));

  bea_cpu_model cpu (.core_clk(core_clk), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata));

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // one cycle forward, giving up when the bound runs out
  task automatic tick(inout int c);
    @(posedge core_clk);
    #1;
    c++;
    if (c > 200) begin
      n_mismatch++;
      conclude();
    end
  endtask : tick

  task automatic stall_len(output int c);
    c = 0;
    while (cpu_stall === 1'b1) tick(c);
  endtask : stall_len

  task automatic wait_ready(output int c);
    c = 0;
    while (ready_irq !== 1'b1) tick(c);
  endtask : wait_ready

  task automatic t_reset();
    cpu.rd(OFS_CTRL, v);
    `CHK(v, 8'h00)
    cpu.rd(OFS_DATA, v);
    `CHK(v, RST_DATA)
    cpu.wr(6'h00, 8'h5a);
    cpu.rd(6'h00, v);
    `CHK(v, 8'h00)
    `CHK({cpu_stall, ready_irq}, 2'b00)
    global_irq_enable = 1'b1;
    #1;
    `CHK(ready_irq, 1'b0)
  endtask : t_reset

  task automatic t_wr_rd(input logic [8:0] a, input logic [7:0] d);
    global_irq_enable = 1'b1;
    cpu.start_write(a, d);
    stall_len(s);
    `CHK(s, 2)
    wait_ready(n);
    `CHK(s + n, WC)
    cpu.wr(OFS_CTRL, 8'h09);
    stall_len(s);
    `CHK(s, 4)
    cpu.rd(OFS_DATA, v);
    `CHK(v, d)
    cpu.rd(OFS_ADDR_HIGH, v);
    `CHK(v, {7'h00, a[8]})
  endtask : t_wr_rd

  // strobe without arm, then with an expired arm
  task automatic t_no_arm();
    cpu.wr(OFS_DATA, 8'h11);
    cpu.wr(OFS_CTRL, 8'h0a);
    cpu.rd(OFS_CTRL, v);
    `CHK(v, 8'h08)
    cpu.wr(OFS_CTRL, 8'h0c);
    cpu.rd(OFS_CTRL, v);
    `CHK(v, 8'h0c)
    repeat (3) @(posedge core_clk);
    cpu.wr(OFS_CTRL, 8'h0a);
    cpu.rd(OFS_CTRL, v);
    `CHK(v, 8'h08)
    cpu.wr(OFS_CTRL, 8'h09);
    stall_len(s);
    cpu.rd(OFS_DATA, v);
    `CHK(v, 8'hc3)
  endtask : t_no_arm

  // refused accesses while a write runs
  task automatic t_busy();
    cpu.start_write(9'h010, 8'h3c);
    stall_len(s);
    cpu.rd(OFS_CTRL, v);
    `CHK(v[1:0], 2'b10)
    `CHK(ready_irq, 1'b0)
    cpu.wr(OFS_ADDR_LOW, 8'h55);
    cpu.wr(OFS_DATA, 8'h99);
    cpu.wr(OFS_CTRL, 8'h09);
    `CHK(cpu_stall, 1'b0)
    cpu.rd(OFS_DATA, v);
    `CHK(v, 8'h99)
    cpu.rd(OFS_ADDR_LOW, v);
    `CHK(v, 8'h10)
    wait_ready(n);
    cpu.rd(OFS_CTRL, v);
    `CHK(v[1], 1'b0)
    cpu.wr(OFS_CTRL, 8'h09);
    stall_len(s);
    cpu.rd(OFS_DATA, v);
    `CHK(v, 8'h3c)
    global_irq_enable = 1'b0;
    #1;
    `CHK(ready_irq, 1'b0)
  endtask : t_busy

  // reset for 20 cycles, then the scenarios
  initial begin
    rst = 1'b1;
    global_irq_enable = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_wr_rd(9'h1ff, 8'ha5);
    t_wr_rd(9'h000, 8'h5a);
    t_wr_rd(9'h0ff, 8'hc3);
    t_no_arm();
    t_busy();
    conclude();
  end
endmodule : tb
